// ==== sess_flash_model.sv ====
// behavioural flash device on the far side
`timescale 1ns/1ps
module sess_flash_model #(
  parameter int WIN_NS  = 2000,
  parameter int ERA_NS  = 40000,
  parameter int SUSP_NS = 5000
) (
  input  wire logic [15:0] addr,   // address
  input  wire logic [7:0]  dq,     // data in
  input  wire logic        weN,    // write strobe
  input  wire logic        oeN,    // output enable
  input  wire logic        ceN,    // chip enable
  input  wire logic        resetN, // reset
  output logic      [7:0]  dqIn    // data out
);
  logic [23:0] seq[5] = '{24'h0555aa, 24'h02aa55, 24'h055580, 24'h0555aa, 24'h02aa55};
  logic [23:0] log[$];
  logic [7:0]  val;
  logic [7:0]  lastD = 8'h00;
  logic        tog = 1'b0;
  logic        susp = 1'b0;
  int          step = 0;
  int          mode = 0;
  int          left = 0;
  realtime     t0 = 0;
  // mode 0 array, 1 window, 2 erasing, 3 suspended
  always @(posedge weN) if (!ceN && resetN) begin
    log.push_back({addr, dq});
    if (mode == 0) begin
      if (step < 5 && {addr, dq} == seq[step]) step++;
      else begin
        if (step == 5 && dq == 8'h30) begin
          mode = 1;
          left = ERA_NS;
          t0 = $realtime;
        end
        step = 0;
      end
    end else if (mode == 1) begin
      if (dq == 8'hb0) mode = 3;
      else if (dq == 8'h30) t0 = $realtime;
      else mode = 0;
    end else if (mode == 2 && dq == 8'hb0 && !susp) begin
      susp = 1'b1;
      t0 = $realtime;
    end else if (mode == 3 && dq == 8'h30) mode = 2;
    else if (mode == 3) step = 0; // other writes keep suspend-read
  end
  always #100 begin
    if (mode == 1 && $realtime - t0 >= WIN_NS) mode = 2;
    else if (mode == 2 && susp && $realtime - t0 >= SUSP_NS) begin
      mode = 3;
      susp = 1'b0;
    end else if (mode == 2 && !susp) begin
      left -= 100;
      if (left <= 0) mode = 0;
    end
  end
  always @(negedge resetN) begin
    mode = 0;
    step = 0;
    susp = 1'b0;
  end
  always @(negedge oeN) tog = ~tog;
  always_comb begin
    case (mode)
      0: val = 8'ha5;
      3: val = {4'h8, 1'b1, tog, 2'b00};
      default: val = {1'b0, tog, 2'b00, mode != 1, tog, 2'b00};
    endcase
  end
  // a released bus never shows the last value
  assign dqIn = (!ceN && !oeN) ? val : ~lastD;
  always @(posedge oeN) lastD = val;
endmodule : sess_flash_model

// ==== sess_host.sv ====
// host controller issuing sector erase, suspend and resume to a nor flash
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sess_host
  import sess_pkg::*;
#(
  parameter int WINDOW_CYC = SESS_WINDOW_CYC,
  parameter int GAP_CYC    = SESS_GAP_CYC,
  parameter int RESUME_CYC = SESS_RESUME_CYC
) (
  input  wire logic        mclk,        // 200 MHz clock
  input  wire logic        rst,         // synchronous reset, active high
  input  wire logic [3:0]  regAddr,     // register address
  input  wire logic [31:0] regWdata,    // register write data
  input  wire logic        regWr,       // write strobe
  input  wire logic        regRd,       // read strobe
  output logic      [31:0] regRdata,    // read data, cycle after strobe
  output logic      [15:0] flashAddr,   // flash address
  output logic      [7:0]  flashDqOut,  // flash data out
  output logic             flashDqOe,   // high while driving data
  input  wire logic [7:0]  flashDqIn,   // flash data in
  output logic             flashWeN,    // write strobe, active low
  output logic             flashOeN,    // output enable, active low
  output logic             flashCeN,    // chip enable, active low
  output logic             flashResetN  // hardware reset, active low
);
  //------------------------------------------------------------
  // pin synchroniser
  //------------------------------------------------------------
  logic [7:0] dqMeta_r, dqSync_r;
  always_ff @(posedge mclk) begin
    dqMeta_r <= flashDqIn;
    dqSync_r <= dqMeta_r;
  end
  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  sess_bus_t  bus_r, bus_nxt;
  logic [3:0]  ph_r, ph_nxt;
  logic [2:0]  seqIdx_r, seqIdx_nxt;
  logic [2:0]  seqLen_r, seqLen_nxt;
  logic [2:0]  cmd_r, cmd_nxt;
  logic [15:0] sector_r, sector_nxt;
  logic [31:0] winCnt_r, winCnt_nxt;
  logic [31:0] gapCnt_r, gapCnt_nxt;
  logic [31:0] resCnt_r, resCnt_nxt;
  logic        window_r, window_nxt;
  logic        busy_r, busy_nxt;
  logic        susp_r, susp_nxt;
  logic        refused_r, refused_nxt;
  logic [7:0]  rdData_r, rdData_nxt;
  logic [31:0] regRdata_nxt;
  logic [15:0] addr_nxt;
  logic [7:0]  dout_nxt;
  logic        oe_nxt, weN_nxt, oeN_nxt, ceN_nxt;
  logic [15:0] cycAddr;
  logic [7:0]  cycData;
  logic        ctrlWr;
  logic [2:0]  ctrlCmd;
  logic        accept;
  always_comb begin
    // six-cycle erase, or single cycle for add, suspend, resume
    case (seqIdx_r)
      3'h0: begin
        cycAddr = SESS_UNLOCK_A1;
        cycData = SESS_UNLOCK_D1;
      end
      3'h1: begin
        cycAddr = SESS_UNLOCK_A2;
        cycData = SESS_UNLOCK_D2;
      end
      3'h2: begin
        cycAddr = SESS_UNLOCK_A1;
        cycData = SESS_SETUP_D;
      end
      3'h3: begin
        cycAddr = SESS_UNLOCK_A1;
        cycData = SESS_UNLOCK_D1;
      end
      3'h4: begin
        cycAddr = SESS_UNLOCK_A2;
        cycData = SESS_UNLOCK_D2;
      end
      default: begin
        cycAddr = sector_r;
        cycData = SESS_SECTOR_D;
      end
    endcase
    if (cmd_r == SESS_CMD_SUSPEND) begin
      cycAddr = sector_r;
      cycData = SESS_SUSPEND_D;
    end else if (cmd_r == SESS_CMD_RESUME) begin
      cycAddr = sector_r;
      cycData = SESS_RESUME_D;
    end
  end
  always_comb begin
    ctrlWr  = regWr && (regAddr == SESS_REG_CTRL);
    ctrlCmd = regWdata[2:0];
    accept  = 1'b0;
    if (ctrlWr && bus_r == SESS_IDLE) begin
      case (ctrlCmd)
        SESS_CMD_ERASE:   accept = !busy_r && !susp_r && !window_r;
        SESS_CMD_ADD:     accept = window_r && gapCnt_r != 32'h0;
        SESS_CMD_SUSPEND: accept = (busy_r || window_r) && !susp_r
                                   && resCnt_r == 32'h0;
        SESS_CMD_RESUME:  accept = susp_r;
        SESS_CMD_READ:    accept = 1'b1;
        default:          accept = 1'b0;
      endcase
    end
  end
  always_comb begin
    bus_nxt = bus_r;
    ph_nxt = ph_r;
    seqIdx_nxt = seqIdx_r;
    seqLen_nxt = seqLen_r;
    cmd_nxt = cmd_r;
    sector_nxt = sector_r;
    winCnt_nxt = (winCnt_r != 32'h0) ? winCnt_r - 32'h1 : 32'h0;
    gapCnt_nxt = (gapCnt_r != 32'h0) ? gapCnt_r - 32'h1 : 32'h0;
    resCnt_nxt = (resCnt_r != 32'h0) ? resCnt_r - 32'h1 : 32'h0;
    window_nxt = window_r;
    busy_nxt = busy_r;
    susp_nxt = susp_r;
    refused_nxt = refused_r;
    rdData_nxt = rdData_r;
    addr_nxt = flashAddr;
    dout_nxt = flashDqOut;
    oe_nxt = 1'b0;
    weN_nxt = 1'b1;
    oeN_nxt = 1'b1;
    ceN_nxt = 1'b1;
    regRdata_nxt = 32'h0;
    if (regWr && regAddr == SESS_REG_STATUS && regWdata[SESS_ST_BUSY]) begin
      busy_nxt = 1'b0; // software saw polling report completion
    end
    // expiry in the cycle of a clear still marks busy
    if (window_r && winCnt_r == 32'h1) begin
      window_nxt = 1'b0;
      busy_nxt   = 1'b1;
    end
    if (regWr && regAddr == SESS_REG_SECTOR) sector_nxt = regWdata[15:0];
    if (ctrlWr) refused_nxt = !accept;
    if (accept) begin
      cmd_nxt = ctrlCmd;
      ph_nxt  = SESS_SETUP_CYC;
      bus_nxt = SESS_SETUP;
      seqIdx_nxt = (ctrlCmd == SESS_CMD_ERASE) ? 3'h0 : 3'h5;
      seqLen_nxt = 3'h5;
      if (ctrlCmd == SESS_CMD_READ) bus_nxt = SESS_OE;
    end
    case (bus_r)
      SESS_SETUP: begin
        addr_nxt = cycAddr;
        dout_nxt = cycData;
        oe_nxt = 1'b1;
        ceN_nxt = 1'b0;
        ph_nxt = ph_r - 4'h1;
        if (ph_r == 4'h1) begin
          bus_nxt = SESS_WE;
          ph_nxt  = SESS_STROBE_CYC;
        end
      end
      SESS_WE: begin
        // strobe stays low for every one of the strobe clocks
        oe_nxt = 1'b1;
        ceN_nxt = 1'b0;
        weN_nxt = 1'b0;
        ph_nxt = ph_r - 4'h1;
        if (ph_r == 4'h1) begin
          bus_nxt = SESS_HOLD;
          ph_nxt  = SESS_HOLD_CYC;
        end
      end
      SESS_HOLD: begin
        oe_nxt = 1'b1;
        ceN_nxt = 1'b0;
        ph_nxt = ph_r - 4'h1;
        if (ph_r == 4'h1) begin
          // queued cycles go out unbroken
          if (seqIdx_r != seqLen_r) begin
            seqIdx_nxt = seqIdx_r + 3'h1;
            bus_nxt = SESS_SETUP;
            ph_nxt  = SESS_SETUP_CYC;
          end else begin
            bus_nxt = SESS_IDLE;
            case (cmd_r)
              SESS_CMD_ERASE, SESS_CMD_ADD: begin
                // window restarts when the hold phase ends, three clocks after strobe rise
                window_nxt = 1'b1;
                winCnt_nxt = WINDOW_CYC;
                gapCnt_nxt = GAP_CYC;
              end
              SESS_CMD_SUSPEND: begin
                window_nxt = 1'b0;
                busy_nxt = 1'b0;
                susp_nxt = 1'b1;
              end
              SESS_CMD_RESUME: begin
                susp_nxt = 1'b0;
                busy_nxt = 1'b1;
                resCnt_nxt = RESUME_CYC;
              end
              default: ;
            endcase
          end
        end
      end
      SESS_OE: begin
        addr_nxt = sector_r;
        ceN_nxt = 1'b0;
        oeN_nxt = 1'b0;
        ph_nxt = ph_r - 4'h1;
        if (ph_r == 4'h1) begin
          rdData_nxt = dqSync_r;
          bus_nxt = SESS_IDLE;
          oeN_nxt = 1'b1;
        end
      end
      default: ;
    endcase
    if (regRd) begin
      case (regAddr)
        SESS_REG_SECTOR: regRdata_nxt = {16'h0, sector_r};
        SESS_REG_STATUS: regRdata_nxt = {27'h0, gapCnt_r != 32'h0, refused_r,
                                         susp_r, window_r, busy_r || bus_r != SESS_IDLE};
        SESS_REG_DATA:   regRdata_nxt = {24'h0, rdData_r};
        default:         regRdata_nxt = 32'h0;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_r <= SESS_IDLE;
      ph_r <= 4'h0;
      seqIdx_r <= 3'h0;
      seqLen_r <= 3'h0;
      cmd_r <= 3'h0;
      sector_r <= 16'h0;
      winCnt_r <= 32'h0;
      gapCnt_r <= 32'h0;
      resCnt_r <= 32'h0;
      window_r <= 1'b0;
      busy_r <= 1'b0;
      susp_r <= 1'b0;
      refused_r <= 1'b0;
      rdData_r <= 8'h0;
      regRdata <= 32'h0;
      flashAddr <= 16'h0;
      flashDqOut <= 8'h0;
      flashDqOe <= 1'b0;
      flashWeN <= 1'b1;
      flashOeN <= 1'b1;
      flashCeN <= 1'b1;
      flashResetN <= 1'b0; // reset aborts any erase
    end else begin
      bus_r <= bus_nxt;
      ph_r <= ph_nxt;
      seqIdx_r <= seqIdx_nxt;
      seqLen_r <= seqLen_nxt;
      cmd_r <= cmd_nxt;
      sector_r <= sector_nxt;
      winCnt_r <= winCnt_nxt;
      gapCnt_r <= gapCnt_nxt;
      resCnt_r <= resCnt_nxt;
      window_r <= window_nxt;
      busy_r <= busy_nxt;
      susp_r <= susp_nxt;
      refused_r <= refused_nxt;
      rdData_r <= rdData_nxt;
      regRdata <= regRdata_nxt;
      flashAddr <= addr_nxt;
      flashDqOut <= dout_nxt;
      flashDqOe <= oe_nxt;
      flashWeN <= weN_nxt;
      flashOeN <= oeN_nxt;
      flashCeN <= ceN_nxt;
      flashResetN <= 1'b1;
    end
  end
endmodule : sess_host

// ==== sess_host_properties.sv ====
// assertions on the host controller ports
`timescale 1ns/1ps
module sess_host_properties
  import sess_pkg::*;
(
  input wire logic        mclk,       // clock
  input wire logic        rst,        // reset
  input wire logic        regRd,      // read strobe
  input wire logic [31:0] regRdata,   // read data
  input wire logic [15:0] flashAddr,  // address
  input wire logic [7:0]  flashDqOut, // data out
  input wire logic        flashDqOe,  // data enable
  input wire logic        flashWeN,   // write strobe
  input wire logic        flashOeN,   // output enable
  input wire logic        flashCeN,   // chip enable
  input wire logic        flashResetN // flash reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_pins: assert property (disable iff (1'b0) rst |=> !flashResetN && flashWeN)
    else $error("reset did not park the flash pins");
  a_we_selects: assert property (!flashWeN |-> !flashCeN && flashOeN && flashDqOe)
    else $error("write strobe without select and drive");
  a_we_width: assert property ($fell(flashWeN) |-> !flashWeN [*8] ##1 flashWeN)
    else $error("write strobe width wrong");
  a_we_stable: assert property (!flashWeN && !$fell(flashWeN) |-> $stable({flashAddr, flashDqOut}))
    else $error("address or data moved under strobe");
  a_setup_span: assert property ($fell(flashWeN) |-> !$past(flashCeN, 4) && $past(flashAddr, 3) == flashAddr)
    else $error("setup phase too short");
  a_hold_span: assert property ($rose(flashWeN) |-> flashWeN [*4])
    else $error("hold phase too short");
  a_rdata_quiet: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its cycle");
  a_read_nodrive: assert property (!flashOeN |-> !flashDqOe && flashWeN)
    else $error("bus driven during a flash read");
  c_suspend: cover property ($fell(flashWeN) && flashDqOut == SESS_SUSPEND_D);
  c_sector: cover property ($fell(flashWeN) && flashDqOut == SESS_SECTOR_D);
  c_read: cover property ($fell(flashOeN));
endmodule : sess_host_properties
bind sess_host sess_host_properties sess_host_properties_i (.mclk(mclk), .rst(rst),
  .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
  .flashDqOe(flashDqOe), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashCeN(flashCeN),
  .flashResetN(flashResetN));

// ==== sess_pkg.sv ====
// package for the sector erase suspend sequencer host controller
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - erase starts with six write cycles
// - host spaces extra sectors under 50 us
// - host keeps interrupts off while queuing
// - other command in window aborts erase
// - hardware reset aborts erase, reissue after
// - resume carries sector address, repeats ignored
// - at least 5 ms resume to suspend
package sess_pkg;
  // register offsets of the controller
  localparam logic [3:0] SESS_REG_CTRL   = 4'h0;
  localparam logic [3:0] SESS_REG_SECTOR = 4'h1;
  localparam logic [3:0] SESS_REG_STATUS = 4'h2;
  localparam logic [3:0] SESS_REG_DATA   = 4'h3;
  // control command codes written to SESS_REG_CTRL[2:0]
  localparam logic [2:0] SESS_CMD_ERASE   = 3'h1;
  localparam logic [2:0] SESS_CMD_ADD     = 3'h2;
  localparam logic [2:0] SESS_CMD_SUSPEND = 3'h3;
  localparam logic [2:0] SESS_CMD_RESUME  = 3'h4;
  localparam logic [2:0] SESS_CMD_READ    = 3'h5;
  // flash command codes and unlock addresses
  localparam logic [15:0] SESS_UNLOCK_A1  = 16'h0555;
  localparam logic [15:0] SESS_UNLOCK_A2  = 16'h02aa;
  localparam logic [7:0]  SESS_UNLOCK_D1  = 8'haa;
  localparam logic [7:0]  SESS_UNLOCK_D2  = 8'h55;
  localparam logic [7:0]  SESS_SETUP_D    = 8'h80;
  localparam logic [7:0]  SESS_SECTOR_D   = 8'h30;
  localparam logic [7:0]  SESS_SUSPEND_D  = 8'hb0;
  localparam logic [7:0]  SESS_RESUME_D   = 8'h30;
  // status field positions
  localparam int SESS_ST_BUSY      = 0;
  localparam int SESS_ST_WINDOW    = 1;
  localparam int SESS_ST_SUSPENDED = 2;
  localparam int SESS_ST_REFUSED   = 3;
  localparam int SESS_ST_GAPOK     = 4;
  // timing: 200 MHz clock
  localparam int SESS_CLK_MHZ      = 200;
  localparam int SESS_WINDOW_US    = 50;
  localparam int SESS_GAP_US       = 40;
  localparam int SESS_RESUME_MS    = 5;
  localparam int SESS_WINDOW_CYC   = SESS_WINDOW_US * SESS_CLK_MHZ;
  localparam int SESS_GAP_CYC      = SESS_GAP_US * SESS_CLK_MHZ;
  localparam int SESS_RESUME_CYC   = SESS_RESUME_MS * 1000 * SESS_CLK_MHZ;
  // bus cycle phase lengths in clocks
  localparam logic [3:0] SESS_SETUP_CYC  = 4'h4;
  localparam logic [3:0] SESS_STROBE_CYC = 4'h8;
  localparam logic [3:0] SESS_HOLD_CYC   = 4'h4;
  typedef enum logic [2:0] {
    SESS_IDLE  = 3'b000,
    SESS_SETUP = 3'b001,
    SESS_WE    = 3'b010,
    SESS_OE    = 3'b011,
    SESS_HOLD  = 3'b100
  } sess_bus_t;
endpackage : sess_pkg

// ==== tb_top.sv ====
// testbench for the sector erase host controller
`timescale 1ns/1ps
module tb_top;
  import sess_pkg::*;
  logic        mclk = 0, rst = 1, regWr = 0, regRd = 0, flashDqOe, flashWeN, flashOeN, flashCeN;
  logic        flashResetN;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, d;
  logic [15:0] flashAddr, s0, s1;
  logic [7:0]  flashDqOut, flashDqIn;
  logic [23:0] exp[$];
  int          fail_count = 0, tests_run = 0;
  always #2.5 mclk = ~mclk;
  sess_host #(.WINDOW_CYC(50), .GAP_CYC(40), .RESUME_CYC(100)) sess_host_i (.mclk(mclk),
    .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashCeN(flashCeN),
    .flashResetN(flashResetN));
  sess_flash_model sess_flash_model_i (.addr(flashAddr), .dq(flashDqOut), .weN(flashWeN),
    .oeN(flashOeN), .ceN(flashCeN), .resetN(flashResetN), .dqIn(flashDqIn));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWdata <= v;
    @(posedge mclk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : bus
  task automatic cmd(input logic [2:0] c, input logic [15:0] s, input logic [7:0] code, input bit ok);
    int n;
    n = sess_flash_model_i.log.size();
    bus(1, SESS_REG_SECTOR, {16'h0, s});
    bus(1, SESS_REG_CTRL, {29'h0, c});
    bus(0, SESS_REG_STATUS, 32'h0);
    chk(d[SESS_ST_REFUSED], !ok);
    if (ok) exp.push_back({s, code});
    for (int i = 0; i < 600 && sess_flash_model_i.log.size() < exp.size(); i++) @(negedge mclk);
    repeat (8) @(posedge mclk);
    chk(sess_flash_model_i.log.size(), exp.size());
    for (int k = n; k < exp.size(); k++) chk(sess_flash_model_i.log[k], exp[k]);
  endtask : cmd
  task automatic frd(input logic [7:0] mask, input logic [7:0] want);
    bus(1, SESS_REG_CTRL, {29'h0, SESS_CMD_READ});
    for (int i = 0; i < 99 && flashOeN; i++) @(negedge mclk);
    for (int i = 0; i < 99 && !flashOeN; i++) @(negedge mclk);
    repeat (4) @(posedge mclk);
    bus(0, SESS_REG_DATA, 32'h0);
    chk(d[7:0] & mask, want);
  endtask : frd
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  initial begin
    #300000;
    fail_count++;
    summarize();
  end
  initial begin
    void'($urandom(33496));
    s0 = 16'($urandom());
    s1 = 16'($urandom());
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    bus(0, SESS_REG_STATUS, 32'h0);
    chk(d, 32'h0);
    frd(8'hff, 8'ha5);
    exp.push_back({SESS_UNLOCK_A1, SESS_UNLOCK_D1});
    exp.push_back({SESS_UNLOCK_A2, SESS_UNLOCK_D2});
    exp.push_back({SESS_UNLOCK_A1, SESS_SETUP_D});
    exp.push_back({SESS_UNLOCK_A1, SESS_UNLOCK_D1});
    exp.push_back({SESS_UNLOCK_A2, SESS_UNLOCK_D2});
    cmd(SESS_CMD_ERASE, s0, SESS_SECTOR_D, 1);
    cmd(SESS_CMD_ADD, s1, SESS_SECTOR_D, 1);
    bus(0, SESS_REG_STATUS, 32'h0);
    chk(d[SESS_ST_WINDOW], 1'b1);
    chk(d[SESS_ST_GAPOK], 1'b1);
    repeat (60) @(posedge mclk);
    cmd(SESS_CMD_ADD, s1, SESS_SECTOR_D, 0);
    cmd(SESS_CMD_SUSPEND, s0, SESS_SUSPEND_D, 1);
    frd(8'h80, 8'h80);
    bus(0, SESS_REG_STATUS, 32'h0);
    chk(d[4:0], 32'h4);
    cmd(SESS_CMD_SUSPEND, s0, SESS_SUSPEND_D, 0);
    cmd(SESS_CMD_RESUME, s0, SESS_RESUME_D, 1);
    cmd(SESS_CMD_RESUME, s0, SESS_RESUME_D, 0);
    cmd(SESS_CMD_SUSPEND, s0, SESS_SUSPEND_D, 0);
    repeat (110) @(posedge mclk);
    cmd(SESS_CMD_SUSPEND, s0, SESS_SUSPEND_D, 1);
    frd(8'h80, 8'h00);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(flashResetN, 1'b0);
    rst <= 1'b0;
    frd(8'hff, 8'ha5);
    summarize();
  end
endmodule : tb_top
